// >>> src/pdmc_pkg.sv
// power-down mode controller: shared constants and types
// assumes a 32-bit ahb-lite register bus and one 20 mhz clock
`default_nettype none

package pdmc_pkg;
	// -------------------------------------------------------------
	// register map (byte addresses)
	// -------------------------------------------------------------
	localparam logic [7:0] OFS_SYS_ONE = 8'h00;
	localparam logic [7:0] OFS_SYS_TWO = 8'h04;
	localparam logic [7:0] OFS_GATE    = 8'h08;
	localparam logic [7:0] OFS_STATUS  = 8'h0c;

	// -------------------------------------------------------------
	// field positions and masks
	// -------------------------------------------------------------
	localparam int          SYS1_STANDBY_SELECT   = 7;
	localparam int          SYS1_STS_LO = 4;
	localparam int          SYS2_SLEEP_SELECT  = 7;
	localparam int          SYS2_DIRECT_TRANSITION_SELECT   = 5;
	localparam int          SYS2_MA_LO  = 2;
	localparam int          GATE_SER    = 5;
	localparam int          GATE_ADC    = 4;
	localparam int          GATE_WDT    = 3;
	localparam int          GATE_TMR2   = 2;
	localparam int          GATE_TMR1   = 1;
	localparam logic [7:0] SYS1_MASK   = 8'hf0;
	localparam logic [7:0] SYS2_MASK   = 8'hbc;
	localparam logic [7:0] GATE_MASK   = 8'h3e;
	localparam logic [7:0] REG_RESET   = 8'h00;

	// -------------------------------------------------------------
	// oscillator wait counts, in clock cycles
	// -------------------------------------------------------------
	localparam int          WAIT_W      = 18;
	localparam logic [17:0] WAIT_1K     = 18'h00400;
	localparam logic [17:0] WAIT_128    = 18'h00080;
	localparam logic [17:0] WAIT_16     = 18'h00010;

	// -------------------------------------------------------------
	// clock divide masks: cycle count minus one
	// -------------------------------------------------------------
	localparam logic [5:0]  DIV1_MASK   = 6'h00;
	localparam logic [5:0]  DIV8_MASK   = 6'h07;
	localparam logic [5:0]  DIV64_MASK  = 6'h3f;
	localparam logic [2:0]  MA_DIV64    = 3'h7;

	typedef enum logic [2:0] {
		PDMC_RESET   = 3'b000,
		PDMC_ACTIVE  = 3'b001,
		PDMC_SLEEP   = 3'b010,
		PDMC_SUBSLP  = 3'b011,
		PDMC_STANDBY = 3'b100,
		PDMC_WAKE    = 3'b101
	} pdmc_mode_e;
endpackage

`default_nettype wire

// >>> src/pdmc_wait_if.sv
// carrier between the mode controller and its wait timer
// assumes both ends share hclk
`default_nettype none

interface pdmc_wait_if;
	logic                         start;
	logic [2:0]                   code;
	logic                         done;
	modport ctrl  (output start, output code, input done);
	modport timer (input start, input code, output done);
endinterface

`default_nettype wire

// >>> src/pdmc_wait_timer.sv
// oscillator stabilisation wait timer
// assumes start is a one-cycle pulse; done stays high until next start
`default_nettype none

module pdmc_wait_timer #(
	parameter logic [17:0] WAIT_8K   = 18'd8192,
	parameter logic [17:0] WAIT_16K  = 18'd16384,
	parameter logic [17:0] WAIT_32K  = 18'd32768,
	parameter logic [17:0] WAIT_64K  = 18'd65536,
	parameter logic [17:0] WAIT_128K = 18'd131072
) (
	// clock and reset
	input  wire logic     hclk,
	input  wire logic     hresetn,
	// control
	pdmc_wait_if.timer    wt
);
	logic [17:0] cnt;
	logic [17:0] load;

	always_comb begin
		unique case (wt.code)
			3'h0: load = WAIT_8K;
			3'h1: load = WAIT_16K;
			3'h2: load = WAIT_32K;
			3'h3: load = WAIT_64K;
			3'h4: load = WAIT_128K;
			3'h5: load = pdmc_pkg::WAIT_1K;
			3'h6: load = pdmc_pkg::WAIT_128;
			3'h7: load = pdmc_pkg::WAIT_16;
		endcase
	end

	// done rises exactly load cycles after the start pulse
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt     <= 18'h00000;
			wt.done <= 1'b1;
		end else if (wt.start) begin
			cnt     <= load - 18'h00001;
			wt.done <= 1'b0;
		end else if (!wt.done) begin
			if (cnt == 18'h00001 || cnt == 18'h00000)
				wt.done <= 1'b1;
			cnt <= cnt - 18'h00001;
		end
	end
endmodule

`default_nettype wire

// >>> src/pdmc_top.sv
// power-down mode controller with ahb-lite registers
// assumes cpu and peripheral inputs are synchronous to hclk
`default_nettype none

// Behaviour
// - gate bits 5 and 4 put serial interface and converter in standby
// - gate bits 2 and 1 stop the second and first timer clocks
// - gate bits 7, 6 and 0 read zero and ignore writes
// - gate bit 3 puts the watchdog in standby
// - watchdog on internal oscillator ignores its gate bit
// - sleep instruction picks sleep, subsleep, standby or direct transition
// - transition with sleep-select set resets timer one, serial, converter
// - direct transition stays active with the new clock rate
// - reset pin low forces reset state from every mode
// - sleep halts the cpu, peripherals keep the selected clock
// - interrupt ends sleep at once, no oscillator wait
// - masked or disabled interrupts never wake a power-down mode
// - standby stops the clock generator and floats the io outputs
// - interrupt in standby waits the selected time before handling
// - after a stable clock, reset handling starts when pin rises
// - subsleep stops the oscillator, cpu and peripherals, ports hold
// - interrupt in subsleep waits the selected time, then handling
// - subsleep and standby hold timer one, serial, converter in reset
// - in standby the watchdog runs only on the internal oscillator
// - standby timer field selects 8192 to 131072, then 1024, 128 or 16 wait states
// - clock select applies after sleep; 0xx full, 100 /8, 111 /64
module pdmc_top #(
	parameter logic [17:0] WAIT_8K   = 18'd8192,
	parameter logic [17:0] WAIT_16K  = 18'd16384,
	parameter logic [17:0] WAIT_32K  = 18'd32768,
	parameter logic [17:0] WAIT_64K  = 18'd65536,
	parameter logic [17:0] WAIT_128K = 18'd131072
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,

	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,

	// cpu side
	input  wire logic        reset_pin_n,
	input  wire logic        sleep_exec,
	input  wire logic        irq_pending,
	input  wire logic        irq_enabled,
	input  wire logic        cpu_imask,
	input  wire logic        dt_irq_enabled,
	output logic             cpu_halt,
	output logic             cpu_reset,
	output logic             int_exc_start,
	output logic             reset_exc_start,
	output logic [2:0]       mode,

	// clock generator
	input  wire logic        wdt_osc_sel,
	output logic             osc_enable,
	output logic             sys_clk_tick,
	output logic             io_hiz,

	// peripheral gates and resets
	output logic             serial_clk_stop,
	output logic             converter_clk_stop,
	output logic             watchdog_clk_stop,
	output logic             second_timer_clk_stop,
	output logic             first_timer_clk_stop,
	output logic             first_timer_rst,
	output logic             serial_rst,
	output logic             converter_rst
);
	// -------------------------------------------------------------
	// registers and state
	// -------------------------------------------------------------
	logic [7:0]           system_control_one;
	logic [7:0]           system_control_two;
	logic [7:0]           peripheral_clock_gate_one;
	pdmc_pkg::pdmc_mode_e state;
	logic                 dp_write;
	logic [7:0]           dp_addr;
	logic [2:0]           clk_sel;
	logic [5:0]           div_cnt;
	logic [5:0]           div_mask;
	logic                 osc_stable;
	logic                 rst_pulse;
	logic                 wake_req;
	logic                 addr_ok;
	logic                 standby_select;
	logic                 sleep_select;
	logic                 direct_transition_select;
	logic [2:0]           standby_timer_field;
	logic [2:0]           active_clock_select;
	logic                 low_power;
	logic [7:0]           rd_byte;

	pdmc_wait_if wt ();

	pdmc_wait_timer #(
		.WAIT_8K   (WAIT_8K),
		.WAIT_16K  (WAIT_16K),
		.WAIT_32K  (WAIT_32K),
		.WAIT_64K  (WAIT_64K),
		.WAIT_128K (WAIT_128K)
	) u_wait (
		.hclk    (hclk),
		.hresetn (hresetn),
		.wt      (wt.timer)
	);

	assign standby_select           = system_control_one[pdmc_pkg::SYS1_STANDBY_SELECT];
	assign standby_timer_field      = system_control_one[pdmc_pkg::SYS1_STS_LO +: 3];
	assign sleep_select             = system_control_two[pdmc_pkg::SYS2_SLEEP_SELECT];
	assign direct_transition_select = system_control_two[pdmc_pkg::SYS2_DIRECT_TRANSITION_SELECT];
	assign active_clock_select      = system_control_two[pdmc_pkg::SYS2_MA_LO +: 3];
	assign wt.code                  = standby_timer_field;
	// wake counts as low power: clocks stay stopped while the oscillator settles
	assign low_power = (state == pdmc_pkg::PDMC_SUBSLP) || (state == pdmc_pkg::PDMC_STANDBY)
		|| (state == pdmc_pkg::PDMC_WAKE);

	// masked or disabled requests are invisible to every low-power state
	assign wake_req = irq_pending && irq_enabled && !cpu_imask;

	// -------------------------------------------------------------
	// ahb-lite slave
	// -------------------------------------------------------------
	// zero wait states: writes land at the end of the data phase,
	// read data are captured from the address phase
	assign addr_ok = hsel && hready && htrans[1];

	always_comb begin
		unique case (haddr[7:0])
			pdmc_pkg::OFS_SYS_ONE: rd_byte = system_control_one;
			pdmc_pkg::OFS_SYS_TWO: rd_byte = system_control_two;
			pdmc_pkg::OFS_GATE:    rd_byte = peripheral_clock_gate_one;
			pdmc_pkg::OFS_STATUS:  rd_byte = {osc_stable, wt.done, 3'h0, state};
			default:               rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_write  <= 1'b0;
			dp_addr   <= 8'h00;
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			dp_write  <= addr_ok && hwrite;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (addr_ok) begin
				dp_addr <= haddr[7:0];
				hrdata  <= {24'h000000, hwrite ? 8'h00 : rd_byte};
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			system_control_one        <= pdmc_pkg::REG_RESET;
			system_control_two        <= pdmc_pkg::REG_RESET;
			peripheral_clock_gate_one <= pdmc_pkg::REG_RESET;
		end else if (dp_write) begin
			unique case (dp_addr)
				pdmc_pkg::OFS_SYS_ONE:
					system_control_one <= hwdata[7:0] & pdmc_pkg::SYS1_MASK;
				pdmc_pkg::OFS_SYS_TWO:
					system_control_two <= hwdata[7:0] & pdmc_pkg::SYS2_MASK;
				pdmc_pkg::OFS_GATE:
					peripheral_clock_gate_one <= hwdata[7:0] & pdmc_pkg::GATE_MASK;
				default: ;
			endcase
		end
	end

	// -------------------------------------------------------------
	// mode sequencer
	// sleep is left at once; subsleep and standby go through wake
	// so that the restarted oscillator settles before any handling
	// starts. a pin reset from those modes waits the same way.
	// -------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state           <= pdmc_pkg::PDMC_RESET;
			clk_sel         <= 3'h0;
			osc_stable      <= 1'b1;
			rst_pulse       <= 1'b0;
			wt.start        <= 1'b0;
			int_exc_start   <= 1'b0;
			reset_exc_start <= 1'b0;
		end else begin
			rst_pulse       <= 1'b0;
			wt.start        <= 1'b0;
			int_exc_start   <= 1'b0;
			reset_exc_start <= 1'b0;
			if (wt.done && !wt.start)
				osc_stable <= 1'b1;
			if (!reset_pin_n) begin
				state <= pdmc_pkg::PDMC_RESET;
				// a halted oscillator restarts and must settle first
				if (state == pdmc_pkg::PDMC_SUBSLP || state == pdmc_pkg::PDMC_STANDBY
					|| state == pdmc_pkg::PDMC_WAKE) begin
					osc_stable <= 1'b0;
					wt.start   <= 1'b1;
				end
			end else begin
				unique case (state)
					pdmc_pkg::PDMC_RESET: begin
						if (osc_stable && wt.done && !wt.start) begin
							state           <= pdmc_pkg::PDMC_ACTIVE;
							reset_exc_start <= 1'b1;
						end
					end

					pdmc_pkg::PDMC_ACTIVE: begin
						if (sleep_exec) begin
							clk_sel   <= active_clock_select;
							rst_pulse <= sleep_select;
							// a refused direct transition falls back to sleep
							if (direct_transition_select && dt_irq_enabled && !cpu_imask) begin
								int_exc_start <= 1'b1;
							end else if (direct_transition_select || !standby_select) begin
								state <= sleep_select && !direct_transition_select
									? pdmc_pkg::PDMC_SUBSLP : pdmc_pkg::PDMC_SLEEP;
							end else begin
								state <= pdmc_pkg::PDMC_STANDBY;
							end
						end
					end

					pdmc_pkg::PDMC_SLEEP: begin
						if (wake_req) begin
							state         <= pdmc_pkg::PDMC_ACTIVE;
							int_exc_start <= 1'b1;
						end
					end

					pdmc_pkg::PDMC_SUBSLP, pdmc_pkg::PDMC_STANDBY: begin
						if (wake_req) begin
							state      <= pdmc_pkg::PDMC_WAKE;
							osc_stable <= 1'b0;
							wt.start   <= 1'b1;
						end
					end

					pdmc_pkg::PDMC_WAKE: begin
						if (wt.done && !wt.start) begin
							state         <= pdmc_pkg::PDMC_ACTIVE;
							int_exc_start <= 1'b1;
							rst_pulse     <= sleep_select;
						end
					end

					default: state <= pdmc_pkg::PDMC_RESET;
				endcase
			end
		end
	end

	// -------------------------------------------------------------
	// operating clock divider
	// -------------------------------------------------------------
	// unlisted 1xx codes fall back to /8
	// the compare wraps at once when a faster rate is chosen
	always_comb begin
		if (!clk_sel[2])
			div_mask = pdmc_pkg::DIV1_MASK;
		else if (clk_sel == pdmc_pkg::MA_DIV64)
			div_mask = pdmc_pkg::DIV64_MASK;
		else
			div_mask = pdmc_pkg::DIV8_MASK;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt      <= 6'h00;
			sys_clk_tick <= 1'b0;
		end else if (!osc_enable || low_power) begin
			div_cnt      <= 6'h00;
			sys_clk_tick <= 1'b0;
		end else begin
			div_cnt      <= (div_cnt >= div_mask) ? 6'h00 : div_cnt + 6'h01;
			sys_clk_tick <= (div_cnt >= div_mask);
		end
	end

	// -------------------------------------------------------------
	// cpu, oscillator and port controls
	// outputs trail the state by one edge
	// -------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cpu_halt   <= 1'b1;
			cpu_reset  <= 1'b1;
			osc_enable <= 1'b1;
			io_hiz     <= 1'b0;
			mode       <= 3'h0;
		end else begin
			mode       <= state;
			cpu_halt   <= state != pdmc_pkg::PDMC_ACTIVE;
			cpu_reset  <= state == pdmc_pkg::PDMC_RESET;
			osc_enable <= state != pdmc_pkg::PDMC_SUBSLP
				&& state != pdmc_pkg::PDMC_STANDBY;
			io_hiz     <= state == pdmc_pkg::PDMC_STANDBY;
		end
	end

	// -------------------------------------------------------------
	// peripheral gates and resets
	// -------------------------------------------------------------
	// the internal oscillator keeps the watchdog alive in any mode,
	// so a stuck gate bit cannot silence it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			serial_clk_stop       <= 1'b0;
			converter_clk_stop    <= 1'b0;
			watchdog_clk_stop     <= 1'b0;
			second_timer_clk_stop <= 1'b0;
			first_timer_clk_stop  <= 1'b0;
			first_timer_rst       <= 1'b0;
			serial_rst            <= 1'b0;
			converter_rst         <= 1'b0;
		end else begin
			serial_clk_stop       <= peripheral_clock_gate_one[pdmc_pkg::GATE_SER] || low_power;
			converter_clk_stop    <= peripheral_clock_gate_one[pdmc_pkg::GATE_ADC] || low_power;
			watchdog_clk_stop     <= !wdt_osc_sel && (peripheral_clock_gate_one[pdmc_pkg::GATE_WDT]
				|| low_power);
			second_timer_clk_stop <= peripheral_clock_gate_one[pdmc_pkg::GATE_TMR2] || low_power;
			first_timer_clk_stop  <= peripheral_clock_gate_one[pdmc_pkg::GATE_TMR1] || low_power;
			first_timer_rst       <= rst_pulse || low_power;
			serial_rst            <= rst_pulse || low_power;
			converter_rst         <= rst_pulse || low_power;
		end
	end
endmodule

`default_nettype wire

// >>> verification/pdmc_top_sva.sv
// checker for the power-down mode controller, bound to its top module
// assumes pdmc_pkg is compiled first; everything runs on hclk
`default_nettype none

module pdmc_top_sva (
	// clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// bus answer
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	// cpu side
	input wire logic        reset_pin_n,
	input wire logic        irq_pending,
	input wire logic        irq_enabled,
	input wire logic        cpu_imask,
	input wire logic        cpu_halt,
	input wire logic        int_exc_start,
	input wire logic [2:0]  mode,
	// clocks and peripherals
	input wire logic        wdt_osc_sel,
	input wire logic        osc_enable,
	input wire logic        sys_clk_tick,
	input wire logic        io_hiz,
	input wire logic        watchdog_clk_stop,
	input wire logic        first_timer_clk_stop,
	input wire logic        first_timer_rst,
	input wire logic        serial_rst,
	input wire logic        converter_rst
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// -------------------------------------------------------------
	// sequences
	// -------------------------------------------------------------
	// mode seen twice so that entry lag between registers cannot fire
	sequence low_s;
		(mode == pdmc_pkg::PDMC_SUBSLP || mode == pdmc_pkg::PDMC_STANDBY) && $past(mode) == mode;
	endsequence
	sequence wake_s;
		mode == pdmc_pkg::PDMC_SLEEP && irq_pending && irq_enabled && !cpu_imask && !int_exc_start;
	endsequence

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not ready okay");
	upper_zero_a: assert property (hrdata[31:8] == 24'h0) else $error("read data upper bits set");
	halt_mode_a: assert property (cpu_halt == (mode != pdmc_pkg::PDMC_ACTIVE)) else $error("halt wrong");
	hiz_mode_a: assert property (io_hiz == (mode == pdmc_pkg::PDMC_STANDBY)) else $error("io float wrong");
	osc_off_a: assert property (low_s |-> !osc_enable) else $error("oscillator on in low power");
	tick_off_a: assert property (low_s |-> !sys_clk_tick) else $error("clock ticks in low power");
	held_reset_a: assert property (low_s |-> first_timer_rst && serial_rst && converter_rst)
		else $error("peripherals not held in reset");
	timer_stop_a: assert property (low_s |-> first_timer_clk_stop) else $error("timer clock runs");
	wdt_run_a: assert property (wdt_osc_sel && $past(wdt_osc_sel) |-> !watchdog_clk_stop)
		else $error("watchdog stopped on internal oscillator");
	wdt_hold_a: assert property (low_s ##0 (!wdt_osc_sel && !$past(wdt_osc_sel)) |-> watchdog_clk_stop)
		else $error("watchdog runs in low power");
	pin_reset_a: assert property (!reset_pin_n |-> ##2 mode == pdmc_pkg::PDMC_RESET)
		else $error("reset pin ignored");
	sleep_wake_a: assert property (wake_s |=> int_exc_start) else $error("sleep not left at once");
	masked_a: assert property (mode == pdmc_pkg::PDMC_SLEEP && cpu_imask |=> !int_exc_start)
		else $error("masked interrupt woke sleep");
endmodule

bind pdmc_top pdmc_top_sva u_sva (.hclk, .hresetn, .hreadyout, .hresp, .hrdata, .reset_pin_n, .irq_pending,
	.irq_enabled, .cpu_imask, .cpu_halt, .int_exc_start, .mode, .wdt_osc_sel, .osc_enable, .sys_clk_tick,
	.io_hiz, .watchdog_clk_stop, .first_timer_clk_stop, .first_timer_rst, .serial_rst, .converter_rst);

`default_nettype wire

// >>> verification/pdmc_cpu_model.sv
// cpu core model: issues sleep instructions and holds interrupt requests
// assumes one-cycle asks from the bench on hclk
`default_nettype none

module pdmc_cpu_model (
	// clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// bench asks
	input  wire logic       ask_sleep,
	input  wire logic       ask_irq,
	input  wire logic [2:0] lag,
	// design side
	input  wire logic       int_exc_start,
	output logic            sleep_exec,
	output logic            irq_pending
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] lag_cnt;
	logic       armed;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			sleep_exec <= 1'b0;
		else
			sleep_exec <= ask_sleep;
	end

	// a slow source raises its request some cycles late, and keeps it until handling starts
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			armed <= 1'b0;
			lag_cnt <= 3'h0;
			irq_pending <= 1'b0;
		end else if (ask_irq) begin
			armed <= 1'b1;
			lag_cnt <= lag;
		end else if (armed && lag_cnt != 3'h0) begin
			lag_cnt <= lag_cnt - 3'h1;
		end else if (armed) begin
			armed <= 1'b0;
			irq_pending <= 1'b1;
		end else if (int_exc_start) begin
			irq_pending <= 1'b0;
		end
	end
endmodule

`default_nettype wire

// >>> verification/tb.sv
// self-checking bench for the power-down mode controller
// assumes pdmc_pkg, the design, its checker and the cpu model are compiled first
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, f, fr;
	logic [31:0] haddr, hwdata, hrdata, seed, q;
	logic [1:0]  htrans;
	logic [2:0]  hsize, mode, lag, c, xm;
	logic [7:0]  v, s1, s2;
	logic        reset_pin_n, sleep_exec, irq_pending, irq_enabled, cpu_imask, dt_irq_enabled, ask_sleep;
	logic        ask_irq, cpu_halt, cpu_reset, int_exc_start, reset_exc_start, wdt_osc_sel, osc_enable;
	logic        sys_clk_tick, io_hiz, serial_clk_stop, converter_clk_stop, watchdog_clk_stop;
	logic        second_timer_clk_stop, first_timer_clk_stop, first_timer_rst, serial_rst, converter_rst;
	logic [2:0]  ma_t [3];
	int          errors, checked, i, n, e;

	assign hready = hreadyout;
	// short waits cap codes 0 to 4 at 64 cycles; the code 5 standby exit still waits 1024
	pdmc_top #(.WAIT_8K(18'd32), .WAIT_16K(18'd40), .WAIT_32K(18'd48), .WAIT_64K(18'd56),
		.WAIT_128K(18'd64)) uut (.*);
	pdmc_cpu_model cpu (.*);

	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	// -------------------------------------------------------------
	// expectations
	// -------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic int exp_wait(input logic [2:0] k);
		case (k)
			3'h5: return 1024;
			3'h6: return 128;
			3'h7: return 16;
			default: return 32 + 8 * k;
		endcase
	endfunction
	function automatic int exp_div(input logic [2:0] m);
		return !m[2] ? 1 : (m == 3'h7) ? 64 : 8;
	endfunction
	function automatic logic [2:0] exp_mode(input logic [7:0] a, input logic [7:0] b, input logic d);
		if (b[5]) return d ? pdmc_pkg::PDMC_ACTIVE : pdmc_pkg::PDMC_SLEEP;
		if (a[7]) return pdmc_pkg::PDMC_STANDBY;
		return b[7] ? pdmc_pkg::PDMC_SUBSLP : pdmc_pkg::PDMC_SLEEP;
	endfunction

	// -------------------------------------------------------------
	// tasks, all entered just after a rising edge
	// -------------------------------------------------------------
	task automatic finish_test;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		checked++;
		if (g !== x) begin
			errors++;
			$display("FAIL %s expected %h seen %h", nm, x, g);
		end
	endtask
	task automatic guard(input int k, input int lim);
		if (k >= lim) begin
			errors++;
			$display("FAIL wait expected event seen none");
			finish_test();
		end
	endtask
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int k;
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= wr;
		k = 0;
		do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 50);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 100);
		r = hrdata;
		guard(k, 100);
	endtask
	task automatic sleep_req;
		ask_sleep <= 1'b1;
		@(posedge hclk);
		ask_sleep <= 1'b0;
		f = 1'b0;
		fr = 1'b0;
		repeat (6) begin
			@(posedge hclk);
			f |= int_exc_start;
			fr |= first_timer_rst;
		end
	endtask
	task automatic tick_gap(output int g);
		int k;
		k = 0;
		while (sys_clk_tick !== 1'b1 && k < 200) begin @(posedge hclk); k++; end
		g = 0;
		do begin @(posedge hclk); g++; end while (sys_clk_tick !== 1'b1 && g < 200);
		guard(k + g, 200);
	endtask
	task automatic wait_mode(input logic [2:0] m);
		int k;
		k = 0;
		while (mode !== m && k < 50) begin @(posedge hclk); k++; end
		guard(k, 50);
	endtask

	// -------------------------------------------------------------
	// main sequence
	// -------------------------------------------------------------
	initial begin
		{hresetn, hsel, hwrite, ask_sleep, ask_irq, cpu_imask, wdt_osc_sel} = '0;
		{reset_pin_n, irq_enabled, dt_irq_enabled} = 3'h7;
		{haddr, hwdata, htrans, lag} = '0;
		hsize = 3'h2;
		ma_t = '{3'h0, 3'h4, 3'h7};
		errors = 0;
		checked = 0;
		seed = 32'h270f;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (i = 0; i < 3; i++) begin
			ahb(1'b0, 8'(i * 4), 32'h0, q);
			chk("reset value", 32'h0, q);
		end
		for (i = 0; i < 8; i++) begin
			seed = xs(seed);
			v = (i == 0) ? 8'hff : seed[7:0];
			wdt_osc_sel <= seed[8];
			ahb(1'b1, pdmc_pkg::OFS_GATE, {24'h0, v}, q);
			ahb(1'b0, pdmc_pkg::OFS_GATE, 32'h0, q);
			chk("gate readback", {24'h0, v & 8'h3e}, q);
			chk("serial stop", 32'(v[5]), 32'(serial_clk_stop));
			chk("converter stop", 32'(v[4]), 32'(converter_clk_stop));
			chk("watchdog stop", 32'(v[3] & ~seed[8]), 32'(watchdog_clk_stop));
			chk("timer two stop", 32'(v[2]), 32'(second_timer_clk_stop));
			chk("timer one stop", 32'(v[1]), 32'(first_timer_clk_stop));
		end
		ahb(1'b1, pdmc_pkg::OFS_GATE, 32'h0, q);
		ahb(1'b1, 8'h40, 32'hff, q);
		ahb(1'b0, 8'h40, 32'h0, q);
		chk("unmapped read", 32'h0, q);
		// sleep, subsleep, standby with every wait code, direct transitions at three rates, then a refused one
		for (i = 0; i < 14; i++) begin
			seed = xs(seed);
			c = 3'(i - 2);
			s1 = (i >= 2 && i < 10) ? {1'b1, c, 4'h0} : 8'h00;
			s2 = (i == 1) ? 8'h80 : (i == 13) ? 8'h20 : (i >= 10) ? {i == 12, 2'b01, ma_t[i - 10], 2'b00} : 8'h00;
			dt_irq_enabled <= (i != 13);
			xm = exp_mode(s1, s2, i != 13);
			ahb(1'b1, pdmc_pkg::OFS_SYS_ONE, {24'h0, s1}, q);
			ahb(1'b1, pdmc_pkg::OFS_SYS_TWO, {24'h0, s2}, q);
			sleep_req();
			chk("mode after sleep", 32'(xm), 32'(mode));
			chk("direct handling", 32'(xm == pdmc_pkg::PDMC_ACTIVE), 32'(f));
			chk("timer one reset", 32'(s1[7] | s2[7]), 32'(fr));
			if (xm == pdmc_pkg::PDMC_ACTIVE) begin
				tick_gap(n);
				chk("tick gap", exp_div(s2[4:2]), n);
			end else begin
				if (i == 0) begin
					tick_gap(n);
					chk("sleep tick gap", 32'h1, n);
					cpu_imask <= 1'b1;
				end
				if (i == 1)
					irq_enabled <= 1'b0;
				lag <= seed[2:0];
				ask_irq <= 1'b1;
				@(posedge hclk);
				ask_irq <= 1'b0;
				if (i < 2) begin
					repeat (40) @(posedge hclk);
					chk("masked wake", 32'(xm), 32'(mode));
					cpu_imask <= 1'b0;
					irq_enabled <= 1'b1;
				end
				n = 0;
				while (int_exc_start !== 1'b1 && n < 2000) begin @(posedge hclk); n++; end
				guard(n, 2000);
				e = (xm == pdmc_pkg::PDMC_SLEEP) ? 0 : exp_wait(s1[6:4]);
				chk("wake wait", 32'h1, 32'(n >= e && n <= e + 16));
				wait_mode(pdmc_pkg::PDMC_ACTIVE);
			end
		end
		ahb(1'b1, pdmc_pkg::OFS_SYS_ONE, 32'hf0, q);
		ahb(1'b1, pdmc_pkg::OFS_SYS_TWO, 32'h0, q);
		sleep_req();
		reset_pin_n <= 1'b0;
		// pin stays low well past the sixteen-state restart wait
		repeat (40) @(posedge hclk);
		chk("pin reset mode", 32'(pdmc_pkg::PDMC_RESET), 32'(mode));
		chk("cpu reset", 32'h1, 32'(cpu_reset));
		reset_pin_n <= 1'b1;
		n = 0;
		while (reset_exc_start !== 1'b1 && n < 50) begin @(posedge hclk); n++; end
		guard(n, 50);
		wait_mode(pdmc_pkg::PDMC_ACTIVE);
		chk("active after reset", 32'(pdmc_pkg::PDMC_ACTIVE), 32'(mode));
		finish_test();
	end
endmodule

`default_nettype wire
